// ===== rtl/thermostat_defs.svh
// Purpose: Shared constants for the thermostat mode control block.
// Assumes: 200 MHz clock, 8-bit two's complement temperature codes.
// Notes:   Times are given in their own unit; cycle counts derive from them.
`ifndef THERMOSTAT_DEFS_SVH
`define THERMOSTAT_DEFS_SVH

`define CLK_FREQ_HZ        200000000
`define CONV_TIME_MS       1000
`define CONV_CYCLES        ((`CLK_FREQ_HZ / 1000) * `CONV_TIME_MS)
`define ESCAPE_PULSES      16
`define TEMP_MAX_CODE      8'h7D
`define TEMP_MIN_CODE      8'hC9
`define TEMP_ZERO_CODE     8'h00

`endif

// ===== rtl/thermostat_pkg.sv
// Purpose: Types shared by the thermostat mode control block.
// Assumes: Constants come from thermostat_defs.svh.
// Notes:   Holds types only.
package thermostat_pkg;

  typedef enum logic [1:0] {
    MODE_SERIAL,
    MODE_THERMO,
    MODE_INIT
  } op_mode_type;

  // Nonvolatile configuration image
  typedef struct packed {
    logic       powerup_thermo;
    logic       output_polarity_bit;
    logic [7:0] high_trip_limit;
    logic [7:0] low_trip_limit;
  } nv_config_type;

  // Host register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } host_req_type;

endpackage

// ===== rtl/alarm_compare.sv
// Purpose: Hysteresis comparator for the thermostat alarm.
// Assumes: Temperature and limits are signed two's complement codes.
// Notes:   Evaluated only on an update strobe, so the level holds between conversions.
`timescale 1ns/1ps
`include "thermostat_defs.svh"
module alarm_compare
  import thermostat_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Comparison inputs
  input  wire logic             update,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] temperature,
  input  wire logic [WIDTH-1:0] high_limit,
  input  wire logic [WIDTH-1:0] low_limit,
  // Result
  output logic                  alarm
);

  logic alarm_reg;
  logic alarm_next;

  // Signed compares; unsigned would trip wrongly below zero
  always_comb begin
    alarm_next = alarm_reg;
    if ($signed(temperature) >= $signed(high_limit)) begin
      alarm_next = 1'b1;
    end else if ($signed(temperature) < $signed(low_limit)) begin
      alarm_next = 1'b0;
    end
  end

  // Alarm state, cleared until the first compare
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      alarm_reg <= 1'b0;
    end else if (update) begin
      alarm_reg <= alarm_next;
    end
  end

  assign alarm = alarm_reg;

endmodule

// ===== rtl/thermostat_mode_control.sv
// Purpose: Mode control, conversion timing and alarm output of a digital thermostat.
// Assumes: Serial bit timing lives outside; registers reached over a plain port.
// Notes:   Reset stands for power-up; nonvolatile values are held across reset.
//
// Behaviour
// - Leaves manufacture in serial mode; shared pin is a bidirectional bus port.
// - Writing the mode bit selects thermostat operation, also on later power-ups; here the live mode changes only at the next power-up.
// - In thermostat mode the pin is only an open-drain alarm output.
// - Escape into serial mode keeps the stored power-up mode bit unchanged.
// - After escape, internal memory including trip limits is read and written.
// - Each reading is an 8-bit signed two's complement value.
// - Range is minus 55 to plus 125 degrees, one degree per step.
// - Code equals degrees: 7Dh, 00h and C9h at the extremes and zero.
// - Temperature is delivered over the serial bus when read in serial mode.
// - Serial mode keeps latest result readable and stores host-written limits.
// - Each conversion completes within at most one second.
// - Thermostat mode converts from power-up continuously, updating after each.
// - Continuous conversions update the output about once per second.
// - Alarm asserts when temperature is at or above the high limit.
// - Alarm stays asserted until temperature is strictly below the low limit.
// - Active level is either high with transistor off or low with it on.
// - Polarity bit one gives active high, zero active low; kept nonvolatile.
// - Power-up mode bit one selects thermostat, zero selects serial mode.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "thermostat_defs.svh"
module thermostat_mode_control
  import thermostat_pkg::*;
#(
  parameter int CONV_CYCLES   = `CONV_CYCLES,
  parameter int ESCAPE_PULSES = `ESCAPE_PULSES
) (
  // Clock and reset (power-up)
  input  wire logic       clk,
  input  wire logic       reset,
  // Escape sequence: supply-off indicator and pin level while off
  input  wire logic       supply_off,
  input  wire logic       pin_in,
  // Temperature sensor front end
  input  wire logic [7:0] sensor_code,
  // Register port: 0 temp, 1 high limit, 2 low limit, 3 status
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata,
  // Shared pin drive
  output logic            pin_out,
  output logic            pin_oe,
  // Mode and conversion status
  output logic            thermo_mode,
  output logic            conv_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map and status layout
  localparam logic [1:0] ADDR_TEMP   = 2'h0;
  localparam logic [1:0] ADDR_HIGH   = 2'h1;
  localparam logic [1:0] ADDR_LOW    = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam int         STAT_DONE   = 7;
  localparam int         STAT_HIGHF  = 6;
  localparam int         STAT_LOWF   = 5;
  localparam int         STAT_MODE   = 3;
  localparam int         STAT_POL    = 1;
  localparam int         CNT_W       = $clog2(CONV_CYCLES + 1);
  localparam int         ESC_W       = $clog2(ESCAPE_PULSES + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [ESC_W-1:0] ESC_LAST  = ESC_W'(ESCAPE_PULSES);

  ////////////////////////////////////////////////////////////////////////////
  // State
  nv_config_type      nv_reg;        // Survives reset like nonvolatile cells
  logic               nv_valid_reg;  // Marks the nonvolatile image as written
  op_mode_type        mode_reg;
  logic               escape_reg;    // Escape armed by pulses while unpowered
  logic [ESC_W-1:0]   esc_cnt_reg;
  logic               pin_prev_reg;
  logic [CNT_W-1:0]   conv_cnt_reg;
  logic [7:0]         temp_reg;
  logic               done_reg;
  logic               high_flag_reg;
  logic               low_flag_reg;
  logic               conv_strobe;
  logic               alarm;
  logic [7:0]         sensor_clamped;
  logic [7:0]         status_value;
  logic               status_write;  // Status write the host may make now

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile configuration: not cleared by reset, so a factory default
  // is loaded once on the first reset only
  always_ff @(posedge clk) begin
    if (reset && nv_valid_reg !== 1'b1) begin
      nv_reg.powerup_thermo      <= 1'b0;
      nv_reg.output_polarity_bit <= 1'b1;
      nv_reg.high_trip_limit     <= `TEMP_MAX_CODE;
      nv_reg.low_trip_limit      <= `TEMP_MIN_CODE;
    end else if (!reset && reg_write && mode_reg == MODE_SERIAL) begin
      unique case (reg_addr)
        ADDR_HIGH:   nv_reg.high_trip_limit <= reg_wdata;
        ADDR_LOW:    nv_reg.low_trip_limit  <= reg_wdata;
        ADDR_STATUS: begin
          nv_reg.powerup_thermo      <= reg_wdata[STAT_MODE];
          nv_reg.output_polarity_bit <= reg_wdata[STAT_POL];
        end
        ADDR_TEMP:   nv_reg <= nv_reg;
      endcase
    end
  end

  // Image valid flag; simulation starts with it unknown, treated as blank
  always_ff @(posedge clk) begin
    if (reset && nv_valid_reg !== 1'b1) begin
      nv_valid_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Escape detector: counts falling edges of the pin while unpowered.
  // Survives reset so it can steer the next power-up.
  always_ff @(posedge clk) begin
    pin_prev_reg <= pin_in;
    if (!supply_off) begin
      esc_cnt_reg <= '0;
    end else if (pin_prev_reg && !pin_in && esc_cnt_reg != ESC_LAST) begin
      esc_cnt_reg <= esc_cnt_reg + ESC_W'(1);
    end
  end

  // Escape armed when the count completes while unpowered. It is held until
  // the mode is chosen, so the supply returning ahead of reset cannot lose it.
  always_ff @(posedge clk) begin
    if (supply_off) begin
      escape_reg <= (esc_cnt_reg == ESC_LAST);
    end else if (mode_reg == MODE_INIT && !reset) begin
      escape_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode picked one cycle after power-up from the stored bit.
  // The escape only flips the live mode, never the stored bit.
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg <= MODE_INIT;
    end else begin
      unique case (mode_reg)
        MODE_INIT: begin
          if (nv_reg.powerup_thermo ^ escape_reg) begin
            mode_reg <= MODE_THERMO;
          end else begin
            mode_reg <= MODE_SERIAL;
          end
        end
        MODE_SERIAL: mode_reg <= MODE_SERIAL;
        MODE_THERMO: mode_reg <= MODE_THERMO;
        default:     mode_reg <= MODE_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timer: one result per period, free running in both modes
  always_ff @(posedge clk) begin
    if (reset || mode_reg == MODE_INIT) begin
      conv_cnt_reg <= '0;
    end else if (conv_cnt_reg == CONV_LAST) begin
      conv_cnt_reg <= '0;
    end else begin
      conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
    end
  end

  assign conv_strobe = (mode_reg != MODE_INIT) && (conv_cnt_reg == CONV_LAST);

  // Clamp the front end into the measurable range
  always_comb begin
    sensor_clamped = sensor_code;
    if ($signed(sensor_code) > $signed(`TEMP_MAX_CODE)) begin
      sensor_clamped = `TEMP_MAX_CODE;
    end else if ($signed(sensor_code) < $signed(`TEMP_MIN_CODE)) begin
      sensor_clamped = `TEMP_MIN_CODE;
    end
  end

  // Result register and done bit
  always_ff @(posedge clk) begin
    if (reset) begin
      temp_reg <= `TEMP_ZERO_CODE;
      done_reg <= 1'b0;
    end else if (conv_strobe) begin
      temp_reg <= sensor_clamped;
      done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software clears are refused in thermostat mode like any other write
  assign status_write = reg_write && (reg_addr == ADDR_STATUS) && (mode_reg == MODE_SERIAL);

  // Sticky excursion flags; a new event wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      high_flag_reg <= 1'b0;
      low_flag_reg  <= 1'b0;
    end else begin
      if (conv_strobe && $signed(sensor_clamped) >= $signed(nv_reg.high_trip_limit)) begin
        high_flag_reg <= 1'b1;
      end else if (status_write && !reg_wdata[STAT_HIGHF]) begin
        high_flag_reg <= 1'b0;
      end
      if (conv_strobe && $signed(sensor_clamped) < $signed(nv_reg.low_trip_limit)) begin
        low_flag_reg <= 1'b1;
      end else if (status_write && !reg_wdata[STAT_LOWF]) begin
        low_flag_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hysteresis comparator, run only in thermostat mode
  alarm_compare #(
    .WIDTH       (8)
  ) u_alarm (
    .clk         (clk),
    .reset       (reset),
    .update      (conv_strobe && mode_reg == MODE_THERMO),
    .clear       (mode_reg != MODE_THERMO),
    .temperature (sensor_clamped),
    .high_limit  (nv_reg.high_trip_limit),
    .low_limit   (nv_reg.low_trip_limit),
    .alarm       (alarm)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status image
  always_comb begin
    status_value             = 8'h00;
    status_value[STAT_DONE]  = done_reg;
    status_value[STAT_HIGHF] = high_flag_reg;
    status_value[STAT_LOWF]  = low_flag_reg;
    status_value[STAT_MODE]  = nv_reg.powerup_thermo;
    status_value[STAT_POL]   = nv_reg.output_polarity_bit;
  end

  // Read data one cycle after the strobe; thermostat mode answers zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read && mode_reg == MODE_SERIAL) begin
      unique case (reg_addr)
        ADDR_TEMP:   reg_rdata <= temp_reg;
        ADDR_HIGH:   reg_rdata <= nv_reg.high_trip_limit;
        ADDR_LOW:    reg_rdata <= nv_reg.low_trip_limit;
        ADDR_STATUS: reg_rdata <= status_value;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: open drain in thermostat mode, so only a low is driven.
  // Serial mode leaves the pin to the bit engine; here it is released.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else if (mode_reg == MODE_THERMO) begin
      pin_out <= 1'b0;
      // Active high releases when alarmed; active low pulls low when alarmed
      pin_oe  <= nv_reg.output_polarity_bit ? !alarm : alarm;
    end else begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end
  end

  // Mode and done indicators
  always_ff @(posedge clk) begin
    if (reset) begin
      thermo_mode <= 1'b0;
      conv_done   <= 1'b0;
    end else begin
      thermo_mode <= (mode_reg == MODE_THERMO);
      conv_done   <= conv_strobe;
    end
  end

endmodule

// ===== dv/thermostat_checker.sv
// Purpose: Port assertions for the thermostat mode control block
// Assumes: CONV_CYCLES matches the instance
// Notes:   Sees the top module ports only
`timescale 1ns/1ps
module thermostat_checker
  import thermostat_pkg::*;
#(
  parameter int CONV_CYCLES = 50
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Register port
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Pin and status
  input wire logic       pin_out,
  input wire logic       pin_oe,
  input wire logic       thermo_mode,
  input wire logic       conv_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  int gap;
  // Cycles since last result; margin covers mode entry latency
  always_ff @(posedge clk) begin
    if (reset || conv_done || !thermo_mode) gap <= 0;
    else gap <= gap + 1;
  end
  AST_DONE_PULSE: assert property (conv_done |=> !conv_done)
    else $error("done pulse too long");
  AST_CONV_BOUND: assert property (gap <= CONV_CYCLES + 4)
    else $error("conversion overdue");
  AST_PIN_LOW_ONLY: assert property (pin_out == 1'b0)
    else $error("open drain pin driven high");
  AST_THERMO_READ: assert property (thermo_mode && reg_read |=> reg_rdata == 8'h00)
    else $error("read answered in thermostat mode");
  AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  // Pin follows the alarm one cycle after the done pulse
  AST_OE_ON_DONE: assert property ($changed(pin_oe) && thermo_mode
    && $past(thermo_mode, 4) |-> $past(conv_done))
    else $error("pin moved between conversions");
  AST_SERIAL_FREE: assert property (!thermo_mode && !$past(thermo_mode) |-> !pin_oe)
    else $error("pin pulled in serial mode");
  // Live mode is only chosen at power-up; thermo_mode shows it two edges later
  AST_MODE_CAUSE: assert property ($rose(thermo_mode) |-> $past(reset, 3))
    else $error("mode changed without cause");
  // Main scenarios reached
  COV_THERMO_DONE: cover property (thermo_mode && conv_done);
  COV_OE_RISE: cover property (thermo_mode && $rose(pin_oe));
  COV_SERIAL_READ: cover property (!thermo_mode && reg_read);
endmodule

bind thermostat_mode_control thermostat_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (
  .clk(clk), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .thermo_mode(thermo_mode), .conv_done(conv_done));

// ===== dv/host_pin_model.sv
// Purpose: Host side of the shared pin, with pull-up
// Assumes: One burst request starts the escape clocking
// Notes:   Device drive is ignored while its supply is off
`timescale 1ns/1ps
module host_pin_model (
  // Clock and control
  input wire logic  clk,
  input wire logic  burst,
  input wire logic  supply_off,
  // Pin
  input wire logic  pin_oe,
  output logic      pin_in,
  output logic      busy
);
  logic [5:0] n_reg;
  // Sixteen low pulses, each followed by a high cycle
  always @(posedge clk) begin
    if (burst && n_reg == 6'h00) n_reg <= 6'h20;
    else if (n_reg != 6'h00) n_reg <= n_reg - 6'h01;
  end
  initial n_reg = 6'h00;
  // Pull-up resolves the wire; unpowered device cannot pull
  assign pin_in = ~(n_reg[0] | (pin_oe & ~supply_off));
  assign busy   = n_reg != 6'h00;
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for thermostat mode control
// Assumes: Short conversion period for simulation
// Notes:   Reset stands for power-up; stored values survive it
`timescale 1ns/1ps
module testbench;
  import thermostat_pkg::*;
  localparam int CONV = 50;
  logic       clk = 0, reset = 1, supply_off = 0, pin_in, burst = 0, busy;
  logic [7:0] sensor_code = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic [1:0] reg_addr = 2'h0;
  logic       reg_write = 0, reg_read = 0, pin_out, pin_oe, thermo_mode, conv_done;
  int         num_errors = 0, checks = 0, cyc = 0;
  // Sensor input beside expected temperature code; last two are clamped
  logic [7:0] trow [8][2] = '{'{8'h7D, 8'h7D}, '{8'h19, 8'h19}, '{8'h00, 8'h00},
    '{8'hFF, 8'hFF}, '{8'hE7, 8'hE7}, '{8'hC9, 8'hC9}, '{8'h7F, 8'h7D}, '{8'h80, 8'hC9}};
  // Alarm walk with high 05h, low FBh: sensor beside expected pin pull
  logic [7:0] arow [6] = '{8'h05, 8'h00, 8'hFB, 8'hFA, 8'h04, 8'h05};
  logic       aexp [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #2.5 clk = ~clk;

  thermostat_mode_control #(.CONV_CYCLES(CONV), .ESCAPE_PULSES(16)) dut (
    .clk(clk), .reset(reset), .supply_off(supply_off), .pin_in(pin_in),
    .sensor_code(sensor_code), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .thermo_mode(thermo_mode), .conv_done(conv_done));
  host_pin_model host (.clk(clk), .burst(burst), .supply_off(supply_off),
    .pin_oe(pin_oe), .pin_in(pin_in), .busy(busy));

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [1:0] a, output logic [7:0] d);
    @(posedge clk) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_done(int n);
    int t;
    repeat (n) begin
      t = 0;
      do begin @(posedge clk); t++; end while (conv_done !== 1'b1 && t < CONV + 10);
      chk("conv_done", {7'h00, conv_done}, 8'h01);
    end
    #1;
  endtask

  task automatic power_up();
    @(posedge clk) reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Supply off with sixteen low pulses on the pin, supply back, power-up
  task automatic escape();
    @(posedge clk) {supply_off, burst} <= 2'b11;
    @(posedge clk) burst <= 1'b0;
    repeat (40) @(posedge clk);
    supply_off <= 1'b0;
    power_up();
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 12000) begin num_errors++; give_verdict(); end
  end

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("thermo_mode", {7'h00, thermo_mode}, 8'h00);
    rd(2'h3, v); chk("status", v, 8'h02);
    rd(2'h1, v); chk("high", v, 8'h7D);
    rd(2'h2, v); chk("low", v, 8'hC9);
    foreach (trow[i]) begin
      sensor_code <= trow[i][0];
      wait_done(2);
      rd(2'h0, v); chk("temp", v, trow[i][1]);
    end
    wr(2'h1, 8'h05); wr(2'h2, 8'hFB); wr(2'h0, 8'h33);
    rd(2'h1, v); chk("high", v, 8'h05);
    rd(2'h2, v); chk("low", v, 8'hFB);
    rd(2'h0, v); chk("temp", v, 8'hC9);
    sensor_code <= 8'h05;
    wr(2'h3, 8'h0A);
    power_up();
    chk("thermo_mode", {7'h00, thermo_mode}, 8'h01);
    chk("pin_oe", {7'h00, pin_oe}, 8'h01);
    rd(2'h1, v); chk("thermo read", v, 8'h00);
    foreach (arow[i]) begin
      sensor_code <= arow[i];
      wait_done(2);
      chk("pin_oe", {7'h00, pin_oe}, {7'h00, aexp[i]});
    end
    escape();
    chk("thermo_mode", {7'h00, thermo_mode}, 8'h00);
    rd(2'h3, v); chk("status", v & 8'h0A, 8'h0A);
    wr(2'h3, 8'h08);
    // Escape flips the stored bit's mode, so a second escape lands in serial again
    escape();
    chk("thermo_mode", {7'h00, thermo_mode}, 8'h00);
    power_up();
    chk("thermo_mode", {7'h00, thermo_mode}, 8'h01);
    chk("pin_oe", {7'h00, pin_oe}, 8'h00);
    wait_done(2);
    chk("pin_oe", {7'h00, pin_oe}, 8'h01);
    give_verdict();
  end
endmodule
